// ===== hw/alarm_status_interrupt_bank.sv
/*
  Page-zero alarm, status and interrupt register bank.
  Assumes a serial port front end that delivers one byte access per strobe,
  synchronous to clk_in, and alarm detectors that drive level inputs.
*/
// Behaviour
// - Eight-bit page select register chooses page.
// - Page select at 0x01, every page.
// - Part number as two BCD read-only bytes.
// - Grade byte: index, zero means A.
// - Revision byte: index, zero means A.
// - Serial address RW, excluded from burn.
// - Internal status bits 0, 1, 2.
// - Internal status bit 3: crystal lock error.
// - Internal status bit 5: serial timeout.
// - Live input missing and off-frequency byte.
// - Live loop unlock and holdover byte.
// - Live loop calibration busy, bits 7:4.
// - Internal sticky flags, cleared by writing zero.
// - Input sticky flags, live layout, write-zero clear.
// - Loop unlock and holdover sticky flags.
// - Loop calibration sticky flags, bits 7:4.
// - Fault mask bits block internal flag interrupts.
// - Fault mask resets to 0x35.
// - Input mask bits block input flag interrupts.
// - Loop mask bits block loop flag interrupts.
// - Ready byte at 0xFE on every page.
`include "alarm_bank_defines.svh"

module alarm_status_interrupt_bank #(
  parameter logic [15:0] PART_NUMBER = 16'h1234, // Arbitrary value.
  parameter alarm_bank_pkg::grade_t GRADE = alarm_bank_pkg::GRADE_A,
  parameter logic [7:0] REVISION = 8'h00, // Arbitrary value.
  parameter logic [7:0] TEMP_GRADE = 8'h00,
  parameter logic [7:0] PACKAGE_CODE = 8'h00, // Arbitrary value.
  parameter logic [6:0] SERIAL_ADDR_RESET = 7'h68
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire alarm_bank_pkg::byte_t reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire alarm_bank_pkg::byte_t reg_wdata_in,
  output alarm_bank_pkg::byte_t reg_rdata_out,
  output logic reg_rvalid_out,
  output alarm_bank_pkg::byte_t page_out,
  output alarm_bank_pkg::serial_addr_t serial_addr_out,
  output alarm_bank_pkg::nibble_t unlock_during_holdover_cfg_out,
  input wire alarm_bank_pkg::byte_t burn_addr_in,
  output alarm_bank_pkg::byte_t burn_data_out,
  output logic burn_excluded_out,
  input wire logic device_ready_in,
  input wire logic device_calibrating_in,
  input wire logic crystal_signal_missing_in,
  input wire logic reference_signal_missing_in,
  input wire logic crystal_lock_error_in,
  input wire logic serial_timeout_in,
  input wire alarm_bank_pkg::nibble_t input_signal_missing_in,
  input wire alarm_bank_pkg::nibble_t input_off_frequency_in,
  input wire alarm_bank_pkg::nibble_t loop_unlocked_in,
  input wire alarm_bank_pkg::nibble_t loop_holdover_in,
  input wire alarm_bank_pkg::nibble_t loop_calibrating_in,
  output logic interrupt_out
);
  import alarm_bank_pkg::*;

  // --------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------
  byte_t page_q;
  byte_t tool_q [3];
  serial_addr_t serial_addr_q;
  byte_t hold_cfg_q;
  byte_t fault_mask_q;
  byte_t input_mask_q;
  byte_t loop_mask_q;
  byte_t live [4];
  byte_t flag_q [4];
  byte_t flag_d [4];
  byte_t flag_ofs [4];
  byte_t enable [4];
  logic on_page0;
  logic wr0;
  byte_t rd_d;
  byte_t burn_d;

  // Only page zero is built here; other pages read zero and ignore writes, except page select and the ready byte.
  assign on_page0 = (page_q == `PAGE_ZERO);
  assign wr0 = reg_wr_in && on_page0;

  // --------------------------------------------------------------------
  // Page select
  // --------------------------------------------------------------------
  // Page switch on write.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      page_q <= `PAGE_RESET;
    end else if (reg_wr_in && reg_addr_in == `OFS_PAGE_SELECT) begin
      page_q <= reg_wdata_in;
    end
  end

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  // Serial address storage.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      serial_addr_q <= 7'h00;
    end else if (wr0 && reg_addr_in == `OFS_SERIAL_ADDR) begin
      serial_addr_q <= reg_wdata_in[6:0];
    end else if (!addr_loaded_q) begin
      serial_addr_q <= SERIAL_ADDR_RESET;
    end
  end

  // The serial address reset value is a parameter, so it is loaded one
  // cycle after release rather than under the asynchronous reset.
  logic addr_loaded_q;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      addr_loaded_q <= 1'b0;
    end else begin
      addr_loaded_q <= 1'b1;
    end
  end
  assign serial_addr_out = addr_loaded_q ? serial_addr_q : SERIAL_ADDR_RESET;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tool_q[0] <= `TOOL_VERSION_RESET;
      tool_q[1] <= `TOOL_VERSION_RESET;
      tool_q[2] <= `TOOL_VERSION_RESET;
      hold_cfg_q <= `HOLD_CFG_RESET;
    end else if (wr0) begin
      if (reg_addr_in == `OFS_TOOL_VERSION_0) begin
        tool_q[0] <= reg_wdata_in;
      end
      if (reg_addr_in == `OFS_TOOL_VERSION_1) begin
        tool_q[1] <= reg_wdata_in;
      end
      if (reg_addr_in == `OFS_TOOL_VERSION_2) begin
        tool_q[2] <= reg_wdata_in;
      end
      if (reg_addr_in == `OFS_HOLD_CFG) begin
        hold_cfg_q <= reg_wdata_in & `HOLD_CFG_BITS;
      end
    end
  end
  assign unlock_during_holdover_cfg_out = hold_cfg_q[3:0];

  // --------------------------------------------------------------------
  // Interrupt masks
  // --------------------------------------------------------------------
  // Mask registers.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fault_mask_q <= `FAULT_MASK_RESET;
      input_mask_q <= `INPUT_MASK_RESET;
      loop_mask_q <= `LOOP_MASK_RESET;
    end else if (wr0) begin
      if (reg_addr_in == `OFS_FAULT_MASK) begin
        fault_mask_q <= reg_wdata_in;
      end
      if (reg_addr_in == `OFS_INPUT_MASK) begin
        input_mask_q <= reg_wdata_in;
      end
      if (reg_addr_in == `OFS_LOOP_MASK) begin
        loop_mask_q <= reg_wdata_in;
      end
    end
  end

  // --------------------------------------------------------------------
  // Live status
  // --------------------------------------------------------------------
  // Internal status byte.
  assign live[0] = {2'b00, serial_timeout_in, 1'b0, crystal_lock_error_in,
                    reference_signal_missing_in, crystal_signal_missing_in,
                    device_calibrating_in};
  assign live[1] = {input_off_frequency_in, input_signal_missing_in};
  assign live[2] = {loop_holdover_in, loop_unlocked_in};
  assign live[3] = {loop_calibrating_in, 4'h0};

  assign flag_ofs[0] = `OFS_INTERNAL_FLAGS;
  assign flag_ofs[1] = `OFS_INPUT_FLAGS;
  assign flag_ofs[2] = `OFS_LOOP_FLAGS;
  assign flag_ofs[3] = `OFS_CAL_FLAGS;
  assign enable[0] = ~fault_mask_q;
  assign enable[1] = ~input_mask_q;
  assign enable[2] = ~loop_mask_q;
  // Calibration flags have no mask in this bank, so they never interrupt.
  assign enable[3] = 8'h00;

  // --------------------------------------------------------------------
  // Sticky flags
  // --------------------------------------------------------------------
  // A live condition in the same cycle as a clearing write keeps its flag,
  // so an event arriving during the clear is never lost.
  for (genvar i = 0; i < 4; i++) begin : g_flag
    always_comb begin
      flag_d[i] = flag_q[i];
      if (wr0 && reg_addr_in == flag_ofs[i]) begin
        flag_d[i] = flag_q[i] & reg_wdata_in;
      end
      flag_d[i] = flag_d[i] | live[i];
    end
    always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        flag_q[i] <= 8'h00;
      end else begin
        flag_q[i] <= flag_d[i];
      end
    end
  end

  // --------------------------------------------------------------------
  // Interrupt
  // --------------------------------------------------------------------
  // Masked flag OR.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      interrupt_out <= 1'b0;
    end else begin
      interrupt_out <= |((flag_d[0] & enable[0]) | (flag_d[1] & enable[1]) |
                         (flag_d[2] & enable[2]) | (flag_d[3] & enable[3]));
    end
  end

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  always_comb begin
    rd_d = 8'h00;
    if (reg_addr_in == `OFS_PAGE_SELECT) begin
      rd_d = page_q;
    end else if (reg_addr_in == `OFS_DEVICE_READY) begin
      rd_d = device_ready_in ? `READY_CODE : 8'h00;
    end else if (on_page0) begin
      unique case (reg_addr_in)
        `OFS_PART_LOW: rd_d = PART_NUMBER[7:0];
        `OFS_PART_HIGH: rd_d = PART_NUMBER[15:8];
        `OFS_DEVICE_GRADE: rd_d = GRADE;
        `OFS_SILICON_REV: rd_d = REVISION;
        `OFS_TOOL_VERSION_0: rd_d = tool_q[0];
        `OFS_TOOL_VERSION_1: rd_d = tool_q[1];
        `OFS_TOOL_VERSION_2: rd_d = tool_q[2];
        `OFS_TEMP_GRADE: rd_d = TEMP_GRADE;
        `OFS_PACKAGE_CODE: rd_d = PACKAGE_CODE;
        `OFS_SERIAL_ADDR: rd_d = {1'b0, serial_addr_out};
        `OFS_INTERNAL_STATUS: rd_d = live[0];
        `OFS_INPUT_STATUS: rd_d = live[1];
        `OFS_LOOP_STATUS: rd_d = live[2];
        `OFS_CAL_STATUS: rd_d = live[3];
        `OFS_INTERNAL_FLAGS: rd_d = flag_q[0] & `INTERNAL_USED_BITS;
        `OFS_INPUT_FLAGS: rd_d = flag_q[1];
        `OFS_LOOP_FLAGS: rd_d = flag_q[2];
        `OFS_CAL_FLAGS: rd_d = flag_q[3] & `CAL_USED_BITS;
        `OFS_HOLD_CFG: rd_d = hold_cfg_q;
        `OFS_FAULT_MASK: rd_d = fault_mask_q;
        `OFS_INPUT_MASK: rd_d = input_mask_q;
        `OFS_LOOP_MASK: rd_d = loop_mask_q;
        default: rd_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= rd_d;
      end
    end
  end
  assign page_out = page_q;

  // --------------------------------------------------------------------
  // Burn image port
  // --------------------------------------------------------------------
  // The burn engine reads writable page-zero bytes other than the serial
  // address here; live and sticky bytes are not part of the image.
  always_comb begin
    burn_d = 8'h00;
    unique case (burn_addr_in)
      `OFS_TOOL_VERSION_0: burn_d = tool_q[0];
      `OFS_TOOL_VERSION_1: burn_d = tool_q[1];
      `OFS_TOOL_VERSION_2: burn_d = tool_q[2];
      `OFS_HOLD_CFG: burn_d = hold_cfg_q;
      `OFS_FAULT_MASK: burn_d = fault_mask_q;
      `OFS_INPUT_MASK: burn_d = input_mask_q;
      `OFS_LOOP_MASK: burn_d = loop_mask_q;
      default: burn_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      burn_data_out <= 8'h00;
      burn_excluded_out <= 1'b0;
    end else begin
      burn_data_out <= burn_d;
      burn_excluded_out <= (burn_addr_in == `OFS_SERIAL_ADDR);
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  a_page_switch: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    reg_wr_in && reg_addr_in == `OFS_PAGE_SELECT |=> page_q == $past(reg_wdata_in))
    else $error("Page select did not take the written value.");

  a_page_hold: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !(reg_wr_in && reg_addr_in == `OFS_PAGE_SELECT) |=> $stable(page_q))
    else $error("Page changed without a page write.");

  a_fault_reset: assert property (@(posedge clk_in)
    $rose(arst_n_in) |-> fault_mask_q == `FAULT_MASK_RESET)
    else $error("Fault mask reset value wrong.");

  a_ready_any: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    reg_rd_in && reg_addr_in == `OFS_DEVICE_READY && device_ready_in
    |=> reg_rvalid_out && reg_rdata_out == `READY_CODE)
    else $error("Ready byte not returned.");

  a_input_live: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    reg_rd_in && on_page0 && reg_addr_in == `OFS_INPUT_STATUS
    |=> reg_rdata_out == $past({input_off_frequency_in, input_signal_missing_in}))
    else $error("Input status byte does not show live detectors.");

  a_sticky_set: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    input_signal_missing_in[0] |=> flag_q[1][0])
    else $error("Input missing flag not latched.");

  a_sticky_keep: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    flag_q[2][4] && !(wr0 && reg_addr_in == `OFS_LOOP_FLAGS) |=> flag_q[2][4])
    else $error("Holdover flag dropped without a clear.");

  a_sticky_clear: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    wr0 && reg_addr_in == `OFS_INTERNAL_FLAGS && !reg_wdata_in[1]
    && !crystal_signal_missing_in |=> !flag_q[0][1])
    else $error("Write of zero did not clear the crystal flag.");

  a_cal_flag: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    loop_calibrating_in[3] |=> flag_q[3][7]
    ##1 (flag_q[3][7] || $past(wr0 && reg_addr_in == `OFS_CAL_FLAGS)))
    else $error("Calibration flag not held.");

  a_mask_block: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    fault_mask_q == 8'hff && input_mask_q == 8'hff && loop_mask_q == 8'hff
    && $stable(fault_mask_q) && $stable(input_mask_q) && $stable(loop_mask_q)
    |-> !interrupt_out)
    else $error("Interrupt raised with all flags masked.");

  a_irq_raise: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    flag_q[1][0] && !input_mask_q[0] |-> ##[0:1] interrupt_out)
    else $error("Unmasked flag did not raise the interrupt.");

  a_addr_burn: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    burn_addr_in == `OFS_SERIAL_ADDR |=> burn_excluded_out && burn_data_out == 8'h00)
    else $error("Serial address leaked into the burn image.");

  c_page_change: cover property (@(posedge clk_in) disable iff (!arst_n_in)
    reg_wr_in && reg_addr_in == `OFS_PAGE_SELECT && reg_wdata_in != 8'h00);
  c_irq_rise: cover property (@(posedge clk_in) disable iff (!arst_n_in)
    $rose(interrupt_out));
  c_clear_irq: cover property (@(posedge clk_in) disable iff (!arst_n_in)
    interrupt_out ##1 wr0 ##1 !interrupt_out);
  c_set_wins: cover property (@(posedge clk_in) disable iff (!arst_n_in)
    wr0 && reg_addr_in == `OFS_INPUT_FLAGS && reg_wdata_in == 8'h00
    && input_signal_missing_in != 4'h0);
endmodule

// ===== include/alarm_bank_defines.svh
/*
  Offsets, field positions and reset values of the page-zero alarm bank.
  Assumes the serial port hands over an 8-bit in-page address.
*/
`ifndef ALARM_BANK_DEFINES_SVH
`define ALARM_BANK_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets within a page
// ----------------------------------------------------------------------
`define OFS_PAGE_SELECT 8'h01
`define OFS_PART_LOW 8'h02
`define OFS_PART_HIGH 8'h03
`define OFS_DEVICE_GRADE 8'h04
`define OFS_SILICON_REV 8'h05
`define OFS_TOOL_VERSION_0 8'h06
`define OFS_TOOL_VERSION_1 8'h07
`define OFS_TOOL_VERSION_2 8'h08
`define OFS_TEMP_GRADE 8'h09
`define OFS_PACKAGE_CODE 8'h0a
`define OFS_SERIAL_ADDR 8'h0b
`define OFS_INTERNAL_STATUS 8'h0c
`define OFS_INPUT_STATUS 8'h0d
`define OFS_LOOP_STATUS 8'h0e
`define OFS_CAL_STATUS 8'h0f
`define OFS_INTERNAL_FLAGS 8'h11
`define OFS_INPUT_FLAGS 8'h12
`define OFS_LOOP_FLAGS 8'h13
`define OFS_CAL_FLAGS 8'h14
`define OFS_HOLD_CFG 8'h16
`define OFS_FAULT_MASK 8'h17
`define OFS_INPUT_MASK 8'h18
`define OFS_LOOP_MASK 8'h19
`define OFS_DEVICE_READY 8'hfe

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define INTERNAL_USED_BITS 8'h2f
`define CAL_USED_BITS 8'hf0
`define HOLD_CFG_BITS 8'h0f
`define PAGE_ZERO 8'h00
`define PAGE_RESET 8'h00
`define FAULT_MASK_RESET 8'h35
`define INPUT_MASK_RESET 8'hff
`define LOOP_MASK_RESET 8'hff
`define HOLD_CFG_RESET 8'h00
`define TOOL_VERSION_RESET 8'h00
`define READY_CODE 8'h0f

`endif

// ===== include/alarm_bank_pkg.sv
/*
  Types shared by the alarm bank.
  Assumes nothing of its surroundings.
*/
package alarm_bank_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] nibble_t;
  typedef logic [6:0] serial_addr_t;
  typedef enum logic [7:0] {
    GRADE_A = 8'h00,
    GRADE_B = 8'h01,
    GRADE_C = 8'h02,
    GRADE_D = 8'h03
  } grade_t;
endpackage

// ===== verif/alarm_status_interrupt_bank_bench.sv
/*
  Self-checking bench of the alarm bank with a queue-based reference model.
  Assumes host_model drives the register port and the bank runs on clk_in.
*/
module alarm_status_interrupt_bank_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import alarm_bank_pkg::*;

  localparam logic [15:0] PN = 16'h2468; // Arbitrary value.
  localparam byte_t GRD = 8'h02;
  localparam byte_t REV = 8'h01; // Arbitrary value.
  localparam byte_t TMP = 8'h00;
  localparam byte_t PKG = 8'h02; // Arbitrary value.
  localparam logic [6:0] SAR = 7'h3c;

  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic act = 1'b0;
  logic [25:0] lvin = '0;
  logic [31:0] rnd = 32'd49;
  logic [7:0] a, wd, rdat, pg_o, bd, ba = 8'h00, ba_q;
  logic wr, rd, rv, bx, irq;
  logic [6:0] sa;
  logic [3:0] hc;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  byte_t mdl [256];
  byte_t lv [4];
  byte_t uf [4] = '{8'h2f, 8'hff, 8'hff, 8'hf0};
  byte_t pgm;
  byte_t rdq [$];
  logic irq_m;
  byte_t msk [3];

  always #25 clk_in = ~clk_in;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  host_model host (.clk_in(clk_in), .rdata_in(rdat), .rvalid_in(rv), .addr_out(a),
    .wr_out(wr), .rd_out(rd), .wdata_out(wd));

  alarm_status_interrupt_bank #(.PART_NUMBER(PN), .GRADE(GRADE_C), .REVISION(REV),
    .TEMP_GRADE(TMP), .PACKAGE_CODE(PKG), .SERIAL_ADDR_RESET(SAR)) DUT (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_addr_in(a), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wd), .reg_rdata_out(rdat), .reg_rvalid_out(rv),
    .page_out(pg_o), .serial_addr_out(sa), .unlock_during_holdover_cfg_out(hc),
    .burn_addr_in(ba), .burn_data_out(bd), .burn_excluded_out(bx),
    .device_ready_in(lvin[25]), .device_calibrating_in(lvin[24]),
    .crystal_signal_missing_in(lvin[23]), .reference_signal_missing_in(lvin[22]),
    .crystal_lock_error_in(lvin[21]), .serial_timeout_in(lvin[20]),
    .input_signal_missing_in(lvin[19:16]), .input_off_frequency_in(lvin[15:12]),
    .loop_unlocked_in(lvin[11:8]), .loop_holdover_in(lvin[7:4]),
    .loop_calibrating_in(lvin[3:0]), .interrupt_out(irq));

  // ----------------------------------------------------------------------
  // Random alarms, sparse so that clears can be seen to take
  // ----------------------------------------------------------------------
  always @(posedge clk_in) begin
    rnd <= lfsr(rnd);
    lvin <= {rnd[25], act ? (rnd[24:0] & rnd[31:7]) : 25'h0};
  end

  // ----------------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------------
  function automatic byte_t exp_rd(input byte_t ad);
    if (ad == 8'hfe) return lvin[25] ? 8'h0f : 8'h00;
    if (ad == 8'h01) return pgm;
    if (pgm != 8'h00) return 8'h00;
    case (ad)
      8'h02: return PN[7:0];
      8'h03: return PN[15:8];
      8'h04: return GRD;
      8'h05: return REV;
      8'h09: return TMP;
      8'h0a: return PKG;
      8'h0c, 8'h0d, 8'h0e, 8'h0f: return lv[ad[1:0]];
      default: return mdl[ad];
    endcase
  endfunction

  function automatic byte_t wmask(input byte_t ad);
    case (ad)
      8'h06, 8'h07, 8'h08, 8'h17, 8'h18, 8'h19: return 8'hff;
      8'h0b: return 8'h7f;
      8'h16: return 8'h0f;
      default: return 8'h00;
    endcase
  endfunction

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      foreach (mdl[i]) mdl[i] = 8'h00;
      mdl[8'h17] = 8'h35;
      mdl[8'h18] = 8'hff;
      mdl[8'h19] = 8'hff;
      mdl[8'h0b] = {1'b0, SAR};
      pgm = 8'h00;
      irq_m = 1'b0;
      msk = '{8'h35, 8'hff, 8'hff};
      ba_q = 8'h00;
    end else begin
      lv[0] = {2'b00, lvin[20], 1'b0, lvin[21], lvin[22], lvin[23], lvin[24]};
      lv[1] = {lvin[15:12], lvin[19:16]};
      lv[2] = {lvin[7:4], lvin[11:8]};
      lv[3] = {lvin[3:0], 4'h0};
      // A read taken with a write returns the old value.
      if (rd) rdq.push_back(exp_rd(a));
      if (wr && pgm == 8'h00) begin
        if (a >= 8'h11 && a <= 8'h14) mdl[a] = mdl[a] & wd;
        else mdl[a] = (mdl[a] & ~wmask(a)) | (wd & wmask(a));
      end
      for (int i = 0; i < 4; i++) mdl[8'h11 + i] = (mdl[8'h11 + i] | lv[i]) & uf[i];
      if (wr && a == 8'h01) pgm = wd;
      // Masked interrupt.
      // The interrupt register sees the masks as they stood before this edge.
      irq_m = |((mdl[8'h11] & ~msk[0]) | (mdl[8'h12] & ~msk[1])
        | (mdl[8'h13] & ~msk[2]));
      msk = '{mdl[8'h17], mdl[8'h18], mdl[8'h19]};
      ba_q = ba;
    end
  end

  // ----------------------------------------------------------------------
  // Comparisons
  // ----------------------------------------------------------------------
  task automatic check(input string nm, input byte_t e, input byte_t s);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic rchk(input byte_t ad);
    byte_t d;
    host.rd(ad, d);
    check($sformatf("read %h", ad), rdq.pop_front(), d);
  endtask

  always @(negedge clk_in) begin
    if (arst_n_in) begin
      check("interrupt", {7'h0, irq_m}, {7'h0, irq});
      check("page", pgm, pg_o);
      check("serial addr", mdl[8'h0b], {1'b0, sa});
      check("hold cfg", mdl[8'h16], {4'h0, hc});
      check("burn excluded", {7'h0, ba_q == 8'h0b}, {7'h0, bx});
      check("burn data", (wmask(ba_q) != 8'h00 && ba_q != 8'h0b) ? mdl[ba_q] : 8'h00, bd);
    end
  end

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // The ceiling is about sixteen times the expected run of about 500 cycles.
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      failures++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_in);
    arst_n_in <= 1'b1;
    for (int i = 0; i < 32; i++) rchk(i[7:0]);
    rchk(8'hfe);
    $display("reset values test done");
    act <= 1'b1;
    for (int i = 0; i < 32; i++) if (i != 1) host.wr(i[7:0], rnd[7:0]);
    for (int i = 0; i < 32; i++) rchk(i[7:0]);
    $display("write and readback test done");
    for (int r = 8'h17; r <= 8'h19; r++) host.wr(r[7:0], 8'h00);
    repeat (40) @(posedge clk_in);
    act <= 1'b0;
    for (int r = 8'h11; r <= 8'h14; r++) rchk(r[7:0]);
    for (int r = 8'h11; r <= 8'h14; r++) host.wr(r[7:0], 8'h00);
    for (int r = 8'h11; r <= 8'h14; r++) rchk(r[7:0]);
    for (int r = 8'h17; r <= 8'h19; r++) host.wr(r[7:0], 8'hff);
    act <= 1'b1;
    repeat (30) @(posedge clk_in);
    act <= 1'b0;
    for (int r = 8'h17; r <= 8'h19; r++) begin
      for (int b = 0; b < 8; b++) host.wr(r[7:0], 8'(~(8'h01 << b)));
      host.wr(r[7:0], 8'hff);
    end
    $display("sticky and interrupt test done");
    host.wr(8'h01, 8'h03);
    rchk(8'h01);
    rchk(8'h0c);
    host.wr(8'h17, 8'h00);
    rchk(8'h17);
    rchk(8'hfe);
    host.wr(8'h01, 8'hff);
    rchk(8'h01);
    host.wr(8'h01, 8'h00);
    rchk(8'h17);
    rchk(8'h20);
    $display("paging test done");
    for (int i = 0; i < 32; i++) begin
      @(posedge clk_in);
      ba <= i[7:0];
    end
    repeat (3) @(posedge clk_in);
    $display("burn image test done");
    tally_and_finish();
  end
endmodule

// ===== verif/host_model.sv
/*
  Host side of the byte register port: one strobe per byte access.
  Assumes the bench calls its tasks and that clk_in is the bank clock.
*/
module host_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in,
  output logic [7:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
  end

  // ----------------------------------------------------------------------
  // Byte write and byte read
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wr_out <= 1'b1;
    wdata_out <= (a == 8'h17) ? (d | 8'hc0) : d;
    @(posedge clk_in);
    wr_out <= 1'b0;
    // Released lines are inverted so a stale byte never looks valid.
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (rvalid_in !== 1'b1 && n < 4);
    d = (rvalid_in === 1'b1) ? rdata_in : 8'hxx;
  endtask
endmodule
